// ==== hdl/eeim_consts.svh ====
`ifndef EEIM_CONSTS_SVH
`define EEIM_CONSTS_SVH

// Register indices; byte address is four times the index
`define EEIM_IDX_INTERRUPT_ENABLE_GROUP0    16'he50a
`define EEIM_IDX_STATUS0  16'he502
`define EEIM_IDX_ACCUMULATION_MODE_REG  16'he701
`define EEIM_IDX_PULSE_OUTPUT_MODE_REG   16'he610

// Event bit positions, shared by mask and status
`define EEIM_B_TOT_ACT    0
`define EEIM_B_FUND_ACT   1
`define EEIM_B_TOT_REA    2
`define EEIM_B_FUND_REA   3
`define EEIM_B_APP        4
`define EEIM_B_LINE       5
`define EEIM_B_ACT_SIGN   6
`define EEIM_B_SUM1       9
`define EEIM_B_REA_SIGN   10
`define EEIM_B_SUM2       13
`define EEIM_B_PULSE      14
`define EEIM_B_DSP        17
`define EEIM_B_SUM3       18
`define EEIM_NEV          19

// Mode register fields
`define EEIM_ACC_ACT_SEL  6
`define EEIM_ACC_REA_SEL  7
`define EEIM_CF_SEL_W     3
`define EEIM_CF_DIS       9

// Reset values
`define EEIM_RST_MASK     19'h00000
`define EEIM_RST_STATUS   19'h00000
`define EEIM_RST_ACCUMULATION_MODE_REG  8'h00
`define EEIM_RST_PULSE_OUTPUT_MODE_REG   12'h000
`define EEIM_RST_PULSE    3'h7

`endif

// ==== hdl/eeim_pkg.sv ====
package eeim_pkg;

  typedef struct packed {
    logic [2:0] tot_act_b30;
    logic [2:0] fund_act_b30;
    logic [2:0] tot_rea_b30;
    logic [2:0] fund_rea_b30;
    logic [2:0] app_b30;
    logic [2:0] tot_act_sign;
    logic [2:0] fund_act_sign;
    logic [2:0] tot_rea_sign;
    logic [2:0] fund_rea_sign;
    logic [7:0] sum_sign;
    logic [7:0] pulse_src_n;
    logic       line_cycle_mode;
    logic       line_cycle_done;
    logic       dsp_done;
  } eeim_meter_s;

  typedef struct packed {
    logic [18:0] mask;
    logic [18:0] status;
    logic [7:0]  accumulation_mode_reg;
    logic [11:0] pulse_output_mode_reg;
    logic [14:0] prev_energy;
    logic [2:0]  prev_act;
    logic [2:0]  prev_rea;
    logic [2:0]  prev_sum;
    logic [2:0]  prev_pulse;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq_n;
    logic [2:0]  pulse_out;
  } eeim_state_s;

endpackage

// ==== hdl/eeim_top.sv ====
// Operation
// RULE1: Mask bit 0 enables interrupt on bit 30 toggle of total active energy.
// RULE2: Mask bit 1 enables interrupt on bit 30 toggle of fundamental active energy.
// RULE3: Mask bit 2 enables interrupt on bit 30 toggle of total reactive energy.
// RULE4: Mask bit 3 enables interrupt on bit 30 toggle of fundamental reactive energy.
// RULE5: Mask bit 4 enables interrupt on bit 30 toggle of apparent energy.
// RULE6: Mask bit 5 enables line-cycle done interrupt while line-cycle mode active.
// RULE7: Mask bits 6-8 enable phase active power sign change, source by mode bit 6.
// RULE8: Mask bits 10-12 enable phase reactive power sign change, source by mode bit 7.
// RULE9: Mask bits 9, 13, 18 enable pulse datapath summed power sign change.
// RULE10: Mask bits 14-16 enable interrupt on falling edge of each pulse output.
// RULE11: Pulse interrupts still fire while the pulse output is disabled.
// RULE12: Each pulse output takes its power quantity from a 3-bit select field.
// RULE13: Mask bit 17 enables interrupt on each periodic DSP computation done.
// RULE14: Mask bits 31:19 reserved, read zero, never affect interrupts.
// RULE15: Absent quantities on reduced variants keep writable mask bits, no interrupt. Sign bits 6-8 and 10-12 are not gated by HAS_FUND.
// RULE16: Interrupt output low while any flagged status bit has its mask bit set.
//
// Implementation choice: the APB register port.
`include "eeim_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module eeim_top #(
  parameter bit HAS_FUND     = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [19:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire eeim_pkg::eeim_meter_s meter,
  output var  logic               irq_n,
  output var  logic               pulse_out_first,
  output var  logic               pulse_out_second,
  output var  logic               pulse_out_third
);
  import eeim_pkg::*;

  eeim_state_s st;
  eeim_state_s next_st;

  function automatic logic addr_hit(input logic [19:0] a, input logic [15:0] idx);
    addr_hit = (a[19:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic pick8(input logic [7:0] v, input logic [2:0] sel);
    pick8 = v[sel];
  endfunction

  logic [`EEIM_NEV-1:0] ev;
  logic [`EEIM_NEV-1:0] clr;
  logic [2:0]           act_now;
  logic [2:0]           rea_now;
  logic [2:0]           sum_now;
  logic [2:0]           pulse_now;
  logic [14:0]          energy_now;
  logic [2:0]           cf_sel [3];
  logic                 setup;
  logic                 access;
  logic                 hit_mask;
  logic                 hit_stat;
  logic                 hit_acc;
  logic                 hit_cf;

  always_comb begin
    next_st    = st;
    ev         = '0;
    clr        = '0;
    energy_now = {meter.app_b30, meter.fund_rea_b30, meter.tot_rea_b30,
                  meter.fund_act_b30, meter.tot_act_b30};
    act_now    = st.accumulation_mode_reg[`EEIM_ACC_ACT_SEL] ? meter.fund_act_sign : meter.tot_act_sign; // RULE7
    rea_now    = st.accumulation_mode_reg[`EEIM_ACC_REA_SEL] ? meter.fund_rea_sign : meter.tot_rea_sign; // RULE8
    for (int k = 0; k < 3; k++) begin
      cf_sel[k]    = st.pulse_output_mode_reg[k*`EEIM_CF_SEL_W +: `EEIM_CF_SEL_W]; // RULE12
      sum_now[k]   = pick8(meter.sum_sign, cf_sel[k]);
      pulse_now[k] = pick8(meter.pulse_src_n, cf_sel[k]); // RULE12
    end
    setup    = psel && !penable && !st.pready;
    access   = psel && penable && st.pready;
    hit_mask = addr_hit(paddr, `EEIM_IDX_INTERRUPT_ENABLE_GROUP0);
    hit_stat = addr_hit(paddr, `EEIM_IDX_STATUS0);
    hit_acc  = addr_hit(paddr, `EEIM_IDX_ACCUMULATION_MODE_REG);
    hit_cf   = addr_hit(paddr, `EEIM_IDX_PULSE_OUTPUT_MODE_REG);

    // Bit 30 toggles on any of the three phases
    ev[`EEIM_B_TOT_ACT]  = |(energy_now[2:0] ^ st.prev_energy[2:0]); // RULE1
    ev[`EEIM_B_FUND_ACT] = HAS_FUND && |(energy_now[5:3] ^ st.prev_energy[5:3]); // RULE2 RULE15
    ev[`EEIM_B_TOT_REA]  = HAS_REACTIVE && |(energy_now[8:6] ^ st.prev_energy[8:6]); // RULE3 RULE15
    ev[`EEIM_B_FUND_REA] = HAS_FUND && HAS_REACTIVE
                           && |(energy_now[11:9] ^ st.prev_energy[11:9]); // RULE4 RULE15
    ev[`EEIM_B_APP]      = |(energy_now[14:12] ^ st.prev_energy[14:12]); // RULE5
    ev[`EEIM_B_LINE]     = meter.line_cycle_done && meter.line_cycle_mode; // RULE6
    ev[`EEIM_B_ACT_SIGN +: 3] = act_now ^ st.prev_act; // RULE7
    ev[`EEIM_B_REA_SIGN +: 3] = HAS_REACTIVE ? (rea_now ^ st.prev_rea) : 3'h0; // RULE8 RULE15
    ev[`EEIM_B_SUM1]     = sum_now[0] ^ st.prev_sum[0]; // RULE9
    ev[`EEIM_B_SUM2]     = sum_now[1] ^ st.prev_sum[1]; // RULE9
    ev[`EEIM_B_SUM3]     = sum_now[2] ^ st.prev_sum[2]; // RULE9
    // Taken before the disable gate so a muted output still interrupts
    ev[`EEIM_B_PULSE +: 3] = st.prev_pulse & ~pulse_now; // RULE10 RULE11
    ev[`EEIM_B_DSP]      = meter.dsp_done; // RULE13

    next_st.prev_energy = energy_now;
    next_st.prev_act    = act_now;
    next_st.prev_rea    = rea_now;
    next_st.prev_sum    = sum_now;
    next_st.prev_pulse  = pulse_now;

    // Zero-wait APB: answer registered in the setup cycle
    next_st.pready  = setup;
    if (setup) begin
      next_st.pslverr = !(hit_mask || hit_stat || hit_acc || hit_cf);
      next_st.prdata  = '0;
      if (!pwrite) begin
        if (hit_mask) next_st.prdata[`EEIM_NEV-1:0] = st.mask; // RULE14
        if (hit_stat) next_st.prdata[`EEIM_NEV-1:0] = st.status;
        if (hit_acc)  next_st.prdata[7:0] = st.accumulation_mode_reg;
        if (hit_cf)   next_st.prdata[11:0] = st.pulse_output_mode_reg;
      end
    end else if (access) begin
      next_st.pslverr = 1'b0;
    end
    if (access && pwrite) begin
      // Upper mask bits are dropped: they can never gate anything
      if (hit_mask) next_st.mask = pwdata[`EEIM_NEV-1:0]; // RULE14 RULE15
      if (hit_stat) clr = pwdata[`EEIM_NEV-1:0];
      if (hit_acc)  next_st.accumulation_mode_reg = pwdata[7:0];
      if (hit_cf)   next_st.pulse_output_mode_reg = pwdata[11:0];
    end

    // Set beats clear in the same cycle
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq_n  = ~|(next_st.status & next_st.mask); // RULE16
    for (int k = 0; k < 3; k++) begin
      next_st.pulse_out[k] = st.pulse_output_mode_reg[`EEIM_CF_DIS + k] ? 1'b1 : pulse_now[k]; // RULE11 RULE12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.mask       <= `EEIM_RST_MASK;
      st.status     <= `EEIM_RST_STATUS;
      st.accumulation_mode_reg    <= `EEIM_RST_ACCUMULATION_MODE_REG;
      st.pulse_output_mode_reg     <= `EEIM_RST_PULSE_OUTPUT_MODE_REG;
      st.prev_pulse <= `EEIM_RST_PULSE;
      st.pulse_out  <= `EEIM_RST_PULSE;
      st.irq_n      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign irq_n            = st.irq_n;
  assign pulse_out_first  = st.pulse_out[0];
  assign pulse_out_second = st.pulse_out[1];
  assign pulse_out_third  = st.pulse_out[2];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  energy_toggle_a: assert property ((energy_now[2:0] != st.prev_energy[2:0]) |=> st.status[0]) // RULE1
    else $error("total active bit 30 toggle not flagged");
  fund_absent_a: assert property (!HAS_FUND |-> !st.status[1] && !st.status[3]) // RULE15
    else $error("absent fundamental quantity flagged");
  line_cycle_a: assert property (meter.line_cycle_done && !meter.line_cycle_mode && !st.status[5]
                                  |=> !st.status[5]) // RULE6
    else $error("line cycle flag outside line mode");
  act_sign_a: assert property ((act_now[0] != st.prev_act[0]) |=> st.status[6]) // RULE7
    else $error("phase a active sign change lost");
  sum_sign_a: assert property ((sum_now[2] != st.prev_sum[2]) |=> st.status[18]) // RULE9
    else $error("third sum sign change lost");
  pulse_fall_a: assert property (st.prev_pulse[0] && !pulse_now[0] |=> st.status[14]) // RULE10
    else $error("pulse falling edge not flagged");
  pulse_mute_a: assert property (st.pulse_output_mode_reg[9] ##1 st.pulse_output_mode_reg[9] |-> pulse_out_first) // RULE11
    else $error("disabled pulse output went low");
  dsp_done_a: assert property (meter.dsp_done |=> st.status[17]) // RULE13
    else $error("dsp done not flagged");
  rsvd_read_a: assert property (pready && !pslverr && hit_mask |-> prdata[31:19] == 13'h0000) // RULE14
    else $error("reserved mask bits read nonzero");
  irq_level_a: assert property (irq_n == !(|(st.status & st.mask))) // RULE16
    else $error("irq level disagrees with status and mask");
  sticky_a: assert property (st.status[4] && !(psel && penable && pwrite && hit_stat) |=> st.status[4]) // RULE5
    else $error("sticky flag lost");

endmodule

`default_nettype wire

// ==== verif/eeim_meter_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module eeim_meter_model (
  input  wire logic                  pclk,
  input  wire logic                  ev_go,
  input  wire logic [3:0]            ev_code,
  output var  eeim_pkg::eeim_meter_s meter
);
  import eeim_pkg::*;
  // One process owns the whole struct; pulse lines go idle high at the first edge
  eeim_meter_s m = '0;
  assign meter = m;
  // Pulses, done strobes and line-cycle mode last one cycle, other levels toggle
  always @(posedge pclk) begin
    m.pulse_src_n <= (ev_go && ev_code == 4'hb) ? 8'hfe : 8'hff;
    m.dsp_done <= ev_go && ev_code == 4'hc;
    m.line_cycle_mode <= ev_go && ev_code == 4'h5;
    m.line_cycle_done <= ev_go && (ev_code == 4'h5 || ev_code == 4'h6);
    if (ev_go) begin
      case (ev_code)
        4'h0: m.tot_act_b30[2] <= ~m.tot_act_b30[2];
        4'h1: m.fund_act_b30[0] <= ~m.fund_act_b30[0];
        4'h2: m.tot_rea_b30[1] <= ~m.tot_rea_b30[1];
        4'h3: m.fund_rea_b30[0] <= ~m.fund_rea_b30[0];
        4'h4: m.app_b30[2] <= ~m.app_b30[2];
        4'h7: m.tot_act_sign[1] <= ~m.tot_act_sign[1];
        4'h8: m.fund_act_sign[1] <= ~m.fund_act_sign[1];
        4'h9: m.tot_rea_sign[2] <= ~m.tot_rea_sign[2];
        4'ha: m.sum_sign[0] <= ~m.sum_sign[0];
        4'hd: m.sum_sign[1] <= ~m.sum_sign[1];
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verif/eeim_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eeim_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module eeim_top_bench;
  import eeim_pkg::*;
  localparam logic [19:0] A_MASK = {2'b00, `EEIM_IDX_INTERRUPT_ENABLE_GROUP0, 2'b00};
  localparam logic [19:0] A_STAT = {2'b00, `EEIM_IDX_STATUS0, 2'b00};
  localparam logic [19:0] A_ACC  = {2'b00, `EEIM_IDX_ACCUMULATION_MODE_REG, 2'b00};
  localparam logic [19:0] A_CF   = {2'b00, `EEIM_IDX_PULSE_OUTPUT_MODE_REG, 2'b00};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [19:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_n;
  logic        pulse_out_first;
  logic        pulse_out_second;
  logic        pulse_out_third;
  logic        ev_go = 1'b0;
  logic [3:0]  ev_code = '0;
  int          lows1 = 0;
  int          lows23 = 0;
  int          base1 = 0;
  int          base23 = 0;
  eeim_meter_s meter;
  int          errors = 0;
  int          comparisons = 0;
  eeim_top i_eeim_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meter(meter),
    .irq_n(irq_n), .pulse_out_first(pulse_out_first), .pulse_out_second(pulse_out_second),
    .pulse_out_third(pulse_out_third));
  eeim_meter_model i_eeim_meter_model (.pclk(pclk), .ev_go(ev_go), .ev_code(ev_code), .meter(meter));
  always #2.5 pclk = ~pclk;
  // Low cycles counted here only; tests compare against a snapshot
  always @(posedge pclk) begin
    if (pulse_out_first === 1'b0) lows1 <= lows1 + 1;
    if (pulse_out_second === 1'b0 && pulse_out_third === 1'b0) lows23 <= lows23 + 1;
  end
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [32:0] exp);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) `CHK({pslverr, prdata}, exp)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ev(input logic [3:0] code, input logic [18:0] exp);
    apb(1'b1, A_STAT, 32'h0007ffff, '0);
    base1 = lows1;
    base23 = lows23;
    ev_code <= code;
    ev_go <= 1'b1;
    @(posedge pclk) ev_go <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, A_STAT, '0, {14'h0000, exp});
    apb(1'b1, A_MASK, {13'h0000, exp}, '0);
    `CHK(irq_n, exp == '0)
    apb(1'b1, A_STAT, {13'h0000, exp}, '0);
    `CHK(irq_n, 1'b1)
    apb(1'b1, A_MASK, '0, '0);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_MASK, '0, '0);
    apb(1'b1, A_MASK, 32'hffffffff, '0);
    apb(1'b0, A_MASK, '0, 33'h00007ffff);
    apb(1'b0, 20'h00006, '0, 33'h100000000);
    ev(4'h0, 19'h00001);
    ev(4'h1, 19'h00002);
    ev(4'h2, 19'h00004);
    ev(4'h3, 19'h00008);
    ev(4'h4, 19'h00010);
    ev(4'h5, 19'h00020);
    ev(4'h6, 19'h00000);
    ev(4'h7, 19'h00080);
    ev(4'h8, 19'h00000);
    ev(4'h9, 19'h01000);
    ev(4'ha, 19'h42200);
    ev(4'hc, 19'h20000);
    ev(4'hb, 19'h1c000);
    `CHK(lows1 - base1, 1)
    `CHK(lows23 - base23, 1)
    apb(1'b1, A_CF, 32'h00000e00, '0);
    ev(4'hb, 19'h1c000);
    `CHK(lows1 - base1, 0)
    `CHK(lows23 - base23, 0)
    apb(1'b1, A_CF, 32'h00000001, '0);
    ev(4'hd, 19'h00200);
    apb(1'b1, A_ACC, 32'h00000040, '0);
    ev(4'h8, 19'h00080);
    ev(4'h7, 19'h00000);
    tally_and_finish;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
